// file: hw/clock_multiplier_config_regs.sv
// configuration and status register bank of the jitter-attenuating clock multiplier
// assumes a byte-wide register port driven by the serial front end on sys_clk;
// monitor and calibration inputs come from logic on the same clock
//
// Notes on behaviour
// - the free-run bit routes the reference oscillator pins onto input path two.
// - output-unsquelch-force at 1 keeps the output clocks on whatever calibration says.
// - the bypass bit connects the selected input straight to the output buffers.
// - the first-priority field names the input preferred first, 00 one, 01 two.
// - the second-priority field names the input ranked second, 00 one, 01 two.
// - register 0 resets to 0x14 with only its three control bits writable.
// - register 1 resets to 0xE4 with its upper four bits read-only.
// - the selection method is manual 00, non-revertive 01, revertive 10, 11 reserved.
// - forced holdover overrides every selection and ignores input quality.
// - with force at 0 and squelch at 1 outputs stay off until a calibration has ended and the loop then shows lock.
`timescale 1ns/1ps

module clock_multiplier_config_regs
    import clkmul_regs_pkg::*;
#(
    parameter logic [11:0] PART_CODE = 12'h5A3,  // arbitrary value
    parameter logic [3:0]  REVISION  = 4'h1,     // arbitrary value
    parameter logic [1:0]  GRADE     = 2'h0      // arbitrary value
) (
    input  wire logic                        sys_clk,          // 200 MHz
    input  wire logic                        nrst,             // async, active low
    input  wire clkmul_regs_pkg::reg_req_t   req,              // register access
    output      logic [7:0]                  rdata,            // read byte, one cycle late
    input  wire logic [1:0]                  input_ok,         // {two, one} inputs usable
    input  wire logic [2:0]                  loss_status,      // {in2, in1, reference}
    input  wire logic [1:0]                  offset_status,    // {in2, in1} offset alarms
    input  wire logic                        loss_of_lock,     // loop not locked
    input  wire logic                        hold_valid,       // history ready for holdover
    input  wire logic [1:0]                  input_select_method, // selection method code
    input  wire logic [1:0]                  manual_select,    // manual input code
    input  wire logic                        forced_holdover,  // force holdover
    input  wire logic                        squelch_during_calibration, // squelch option
    input  wire logic                        cal_done,         // calibration finished pulse
    output      clkmul_regs_pkg::cfg_t       cfg               // control outputs
);
    import clkmul_regs_pkg::*;

    bank_state_t st;
    bank_state_t next_st;

    logic       wr_hit;
    logic [7:0] rd_val;
    logic [2:0] offset_live;
    logic [1:0] first_code;
    logic [1:0] second_code;
    logic       first_is_valid;
    logic       second_is_valid;
    logic       first_two;
    logic       second_two;

    assign wr_hit      = req.wr;
    assign offset_live = {offset_status, loss_of_lock};
    assign first_code  = st.input_priority[PRIO1_LSB +: 2];
    assign second_code = st.input_priority[PRIO2_LSB +: 2];
    // reserved priority codes name no input at all
    assign first_is_valid  = (first_code == INPUT_CODE_ONE) || (first_code == INPUT_CODE_TWO);
    assign second_is_valid = (second_code == INPUT_CODE_ONE) || (second_code == INPUT_CODE_TWO);
    assign first_two       = (first_code == INPUT_CODE_TWO);
    assign second_two      = (second_code == INPUT_CODE_TWO);

    always_comb begin
        rd_val = 8'h00;
        unique case (req.addr)
            ADDR_CONTROL_MODE:   rd_val = st.control_mode;
            ADDR_INPUT_PRIORITY: rd_val = st.input_priority;
            ADDR_OUT2_DIV_MID:   rd_val = st.out2_mid;
            ADDR_OUT2_DIV_LOW:   rd_val = st.out2_low;
            ADDR_FB_DIV_HIGH:    rd_val = st.fb_high;
            ADDR_FB_DIV_MID:     rd_val = st.fb_mid;
            ADDR_FB_DIV_LOW:     rd_val = st.fb_low;
            ADDR_IN1_DIV_HIGH:   rd_val = st.in1_high;
            ADDR_IN1_DIV_MID:    rd_val = st.in1_mid;
            ADDR_IN1_DIV_LOW:    rd_val = st.in1_low;
            ADDR_IN2_DIV_HIGH:   rd_val = st.in2_high;
            ADDR_IN2_DIV_MID:    rd_val = st.in2_mid;
            ADDR_IN2_DIV_LOW:    rd_val = st.in2_low;
            ADDR_RATE_RANGES:    rd_val = st.rate_ranges;
            ADDR_ACTIVE_INPUT:   rd_val = {6'h00, st.sel == SEL_TWO, st.sel == SEL_ONE};
            ADDR_LOSS_STATUS:    rd_val = {5'h00, loss_status};
            ADDR_OFFSET_STATUS:  rd_val = {1'b0, hold_valid, 3'h0, offset_live};
            ADDR_LOSS_FLAGS:     rd_val = {5'h00, st.loss_flags};
            ADDR_OFFSET_FLAGS:   rd_val = {4'h0, st.offset_flags, 1'b0};
            ADDR_PART_HIGH:      rd_val = PART_CODE[11:4];
            ADDR_PART_LOW_REV:   rd_val = {PART_CODE[3:0], REVISION};
            ADDR_RESET_CAL:      rd_val = {6'h00, GRADE};  // command bits self-clear
            ADDR_QUICK_LOCK:     rd_val = st.quick_lock;
            ADDR_LOSS_EN_HIGH:   rd_val = st.loss_en_high;
            ADDR_LOSS_OFS_EN:    rd_val = st.loss_ofs_en;
            ADDR_OUT1_SKEW:      rd_val = st.out1_skew;
            ADDR_OUT2_SKEW:      rd_val = st.out2_skew;
            default:             rd_val = 8'h00;
        endcase
    end

    always_comb begin
        next_st            = st;
        next_st.soft_reset = 1'b0;
        next_st.cal_start  = 1'b0;
        if (req.rd) begin
            next_st.rdata = rd_val;
        end

        // read-only bits are forced back to their reset pattern on every write
        if (wr_hit) begin
            unique case (req.addr)
                ADDR_CONTROL_MODE: begin
                    next_st.control_mode = (req.wdata & CONTROL_MODE_WMASK)
                                         | (CONTROL_MODE_RESET & ~CONTROL_MODE_WMASK);
                end
                ADDR_INPUT_PRIORITY: begin
                    next_st.input_priority = (req.wdata & INPUT_PRIORITY_WMASK)
                                       | (INPUT_PRIORITY_RESET & ~INPUT_PRIORITY_WMASK);
                end
                ADDR_OUT2_DIV_MID: next_st.out2_mid = req.wdata;
                ADDR_OUT2_DIV_LOW: next_st.out2_low = req.wdata;
                ADDR_FB_DIV_HIGH:  next_st.fb_high  = req.wdata & 8'hEF;
                ADDR_FB_DIV_MID:   next_st.fb_mid   = req.wdata;
                ADDR_FB_DIV_LOW:   next_st.fb_low   = req.wdata;
                ADDR_IN1_DIV_HIGH: next_st.in1_high = req.wdata & 8'h07;
                ADDR_IN1_DIV_MID:  next_st.in1_mid  = req.wdata;
                ADDR_IN1_DIV_LOW:  next_st.in1_low  = req.wdata;
                ADDR_IN2_DIV_HIGH: next_st.in2_high = req.wdata & 8'h07;
                ADDR_IN2_DIV_MID:  next_st.in2_mid  = req.wdata;
                ADDR_IN2_DIV_LOW:  next_st.in2_low  = req.wdata;
                ADDR_RATE_RANGES:  next_st.rate_ranges  = req.wdata & 8'h3F;
                ADDR_QUICK_LOCK:   next_st.quick_lock   = req.wdata & 8'h01;
                ADDR_LOSS_EN_HIGH: next_st.loss_en_high = req.wdata & 8'h03;
                ADDR_LOSS_OFS_EN:  next_st.loss_ofs_en  = req.wdata & 8'h33;
                ADDR_OUT1_SKEW:    next_st.out1_skew    = req.wdata;
                ADDR_OUT2_SKEW:    next_st.out2_skew    = req.wdata;
                ADDR_RESET_CAL: begin
                    next_st.soft_reset = req.wdata[SOFT_RESET_BIT];
                    next_st.cal_start  = req.wdata[CAL_START_BIT];
                end
                // writing 0 clears a flag; writing 1 leaves it alone
                ADDR_LOSS_FLAGS:   next_st.loss_flags   = st.loss_flags & req.wdata[2:0];
                ADDR_OFFSET_FLAGS: begin
                    next_st.offset_flags = st.offset_flags & req.wdata[OFFSET_FLAG_LSB +: 3];
                end
                default: ;
            endcase
        end
        // a live alarm in the clearing cycle keeps its flag set
        next_st.loss_flags   = next_st.loss_flags | loss_status;
        next_st.offset_flags = next_st.offset_flags | offset_live;

        // a new calibration run restarts the squelch qualification
        if (st.cal_start) begin
            next_st.cal_seen = 1'b0;
            next_st.cal_good = 1'b0;
        end else if (st.cal_seen && !loss_of_lock) begin
            next_st.cal_good = 1'b1;
        end
        // a run finishing in the restart cycle still counts
        if (cal_done) begin
            next_st.cal_seen = 1'b1;
        end

        // input selection
        if (forced_holdover) begin
            next_st.sel = SEL_HOLD;
        end else begin
            unique case (input_select_method)
                METHOD_MANUAL: begin
                    if (manual_select == INPUT_CODE_ONE) begin
                        next_st.sel = SEL_ONE;
                    end else if (manual_select == INPUT_CODE_TWO) begin
                        next_st.sel = SEL_TWO;
                    end
                end
                METHOD_NONREVERT, METHOD_REVERT: begin
                    // non-revertive keeps a healthy current input
                    if (input_select_method == METHOD_NONREVERT
                        && ((st.sel == SEL_ONE && input_ok[0])
                            || (st.sel == SEL_TWO && input_ok[1]))) begin
                        next_st.sel = st.sel;
                    end else if (first_is_valid && input_ok[first_two]) begin
                        next_st.sel = first_two ? SEL_TWO : SEL_ONE;
                    end else if (second_is_valid && input_ok[second_two]) begin
                        next_st.sel = second_two ? SEL_TWO : SEL_ONE;
                    end else begin
                        next_st.sel = SEL_HOLD;
                    end
                end
                default: ;  // reserved method keeps the current choice
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st                <= '0;
            st.control_mode   <= CONTROL_MODE_RESET;
            st.input_priority <= INPUT_PRIORITY_RESET;
            st.sel            <= SEL_ONE;
        end else begin
            st <= next_st;
        end
    end

    assign rdata = st.rdata;

    always_comb begin
        cfg                  = '0;
        cfg.ref_to_input_two = st.control_mode[FREE_RUN_BIT];
        cfg.bypass           = st.control_mode[BYPASS_BIT];
        // forcing bypasses calibration squelch; the frequency may be far off until then
        cfg.outputs_on       = st.control_mode[UNSQUELCH_BIT]
                             | (squelch_during_calibration ? st.cal_good : st.cal_seen);
        cfg.holdover         = (st.sel == SEL_HOLD);
        cfg.input_two_active = (st.sel == SEL_TWO);
        // lowest-numbered register carries the most significant byte
        cfg.out2_div_low     = {st.out2_mid, st.out2_low};
        cfg.fb_div_high      = st.fb_high[FB_HS_LSB +: 3];
        cfg.fb_div_low       = {st.fb_high[3:0], st.fb_mid, st.fb_low};
        cfg.in1_div          = {st.in1_high[2:0], st.in1_mid, st.in1_low};
        cfg.in2_div          = {st.in2_high[2:0], st.in2_mid, st.in2_low};
        cfg.rate_ranges      = st.rate_ranges;
        cfg.quick_lock       = st.quick_lock[0];
        cfg.loss_enables     = {st.loss_en_high[1:0], st.loss_ofs_en[5:4]};
        cfg.offset_enables   = st.loss_ofs_en[1:0];
        cfg.out1_skew        = st.out1_skew;
        cfg.out2_skew        = st.out2_skew;
        cfg.soft_reset       = st.soft_reset;
        cfg.cal_start        = st.cal_start;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    a_reg0_reserved_fixed: assert property (
        (st.control_mode & ~CONTROL_MODE_WMASK) == (CONTROL_MODE_RESET & ~CONTROL_MODE_WMASK))
        else $error("control register reserved bits changed");

    a_reg1_upper_fixed: assert property (
        req.wr && req.addr == ADDR_INPUT_PRIORITY |=> st.input_priority[7:4] == 4'hE)
        else $error("priority register upper bits changed");

    a_prio_readback: assert property (
        req.wr && req.addr == ADDR_INPUT_PRIORITY ##1 req.rd && req.addr == ADDR_INPUT_PRIORITY
        && !(req.wr && req.addr == ADDR_INPUT_PRIORITY)
        |=> rdata[3:0] == $past(req.wdata[3:0], 2))
        else $error("priority field does not read back");

    a_free_run_route: assert property (
        req.wr && req.addr == ADDR_CONTROL_MODE
        |=> cfg.ref_to_input_two == $past(req.wdata[FREE_RUN_BIT]))
        else $error("free-run routing does not follow write");

    a_bypass_write: assert property (
        req.wr && req.addr == ADDR_CONTROL_MODE |=> cfg.bypass == $past(req.wdata[BYPASS_BIT]))
        else $error("bypass does not follow write");

    a_force_unsquelch: assert property (
        st.control_mode[UNSQUELCH_BIT] |-> cfg.outputs_on)
        else $error("outputs squelched while forced on");

    a_squelch_until_cal: assert property (
        !st.control_mode[UNSQUELCH_BIT] && squelch_during_calibration && !st.cal_seen
        |-> !cfg.outputs_on)
        else $error("outputs on before calibration");

    a_hold_forced: assert property (
        forced_holdover |=> cfg.holdover && !cfg.input_two_active)
        else $error("forced holdover not taken");

    a_revert_first: assert property (
        !forced_holdover && input_select_method == METHOD_REVERT
        && first_code == INPUT_CODE_TWO && input_ok[1] |=> cfg.input_two_active)
        else $error("first priority input not chosen");

    a_revert_second: assert property (
        !forced_holdover && input_select_method == METHOD_REVERT && first_code == INPUT_CODE_ONE
        && !input_ok[0] && second_code == INPUT_CODE_TWO && input_ok[1]
        |=> cfg.input_two_active)
        else $error("second priority input not chosen");

    a_manual_select: assert property (
        !forced_holdover && input_select_method == METHOD_MANUAL
        && manual_select == INPUT_CODE_TWO |=> cfg.input_two_active)
        else $error("manual selection ignored");

    a_flag_set_wins: assert property (
        loss_status[1] && req.wr && req.addr == ADDR_LOSS_FLAGS |=> st.loss_flags[1])
        else $error("loss flag lost on clear");

    // restart, squelch, alarm, selection and divider guards
    a_cal_restart_clear: assert property (
        st.cal_start && !cal_done |=> !st.cal_seen && !st.cal_good)
        else $error("calibration restart kept state");

    a_squelch_no_cal: assert property (
        !st.control_mode[UNSQUELCH_BIT] && !squelch_during_calibration && !st.cal_seen
        |-> !cfg.outputs_on)
        else $error("outputs on before any calibration");

    a_nonrevert_keep: assert property (
        !forced_holdover && input_select_method == METHOD_NONREVERT
        && cfg.input_two_active && input_ok[1] |=> cfg.input_two_active)
        else $error("healthy input dropped");

    a_revert_to_hold: assert property (
        !forced_holdover && input_select_method == METHOD_REVERT && input_ok == 2'b00
        |=> cfg.holdover)
        else $error("no holdover without inputs");

    a_status_live: assert property (
        req.rd && req.addr == ADDR_LOSS_STATUS |=> rdata[2:0] == $past(loss_status))
        else $error("live loss status misread");

    a_loss_flag_set: assert property (
        loss_status[0] |=> st.loss_flags[0])
        else $error("loss flag not set");

    a_offset_flag_set: assert property (
        loss_of_lock |=> st.offset_flags[0])
        else $error("lock flag not set");

    a_fb_high_field: assert property (
        req.wr && req.addr == ADDR_FB_DIV_HIGH
        |=> cfg.fb_div_high == $past(req.wdata[FB_HS_LSB +: 3]))
        else $error("feedback high divider misplaced");

    a_in1_div_order: assert property (
        req.wr && req.addr == ADDR_IN1_DIV_HIGH
        |=> cfg.in1_div[18:16] == $past(req.wdata[2:0]))
        else $error("input divider byte order");

    c_nonrevert_hold: cover property (
        input_select_method == METHOD_NONREVERT && cfg.input_two_active ##1 !cfg.holdover);
    c_cal_unsquelch: cover property (!cfg.outputs_on ##1 cfg.outputs_on);
    c_flag_clear: cover property (st.loss_flags[0] ##1 !st.loss_flags[0]);
    c_manual_two: cover property (
        input_select_method == METHOD_MANUAL && manual_select == INPUT_CODE_TWO);
    c_flag_kept: cover property (loss_status[1] && req.wr && req.addr == ADDR_LOSS_FLAGS);

endmodule : clock_multiplier_config_regs

// file: common/clkmul_regs_pkg.sv
// register map, field layout and carrier types of the clock multiplier config bank
// assumes an 8-bit register port with byte addresses equal to the register numbers
package clkmul_regs_pkg;

    // register addresses
    localparam logic [7:0] ADDR_CONTROL_MODE   = 8'h00;
    localparam logic [7:0] ADDR_INPUT_PRIORITY = 8'h01;
    localparam logic [7:0] ADDR_OUT2_DIV_MID   = 8'h23;
    localparam logic [7:0] ADDR_OUT2_DIV_LOW   = 8'h24;
    localparam logic [7:0] ADDR_FB_DIV_HIGH    = 8'h28;
    localparam logic [7:0] ADDR_FB_DIV_MID     = 8'h29;
    localparam logic [7:0] ADDR_FB_DIV_LOW     = 8'h2A;
    localparam logic [7:0] ADDR_IN1_DIV_HIGH   = 8'h2B;
    localparam logic [7:0] ADDR_IN1_DIV_MID    = 8'h2C;
    localparam logic [7:0] ADDR_IN1_DIV_LOW    = 8'h2D;
    localparam logic [7:0] ADDR_IN2_DIV_HIGH   = 8'h2E;
    localparam logic [7:0] ADDR_IN2_DIV_MID    = 8'h2F;
    localparam logic [7:0] ADDR_IN2_DIV_LOW    = 8'h30;
    localparam logic [7:0] ADDR_RATE_RANGES    = 8'h37;
    localparam logic [7:0] ADDR_ACTIVE_INPUT   = 8'h80;
    localparam logic [7:0] ADDR_LOSS_STATUS    = 8'h81;
    localparam logic [7:0] ADDR_OFFSET_STATUS  = 8'h82;
    localparam logic [7:0] ADDR_LOSS_FLAGS     = 8'h83;
    localparam logic [7:0] ADDR_OFFSET_FLAGS   = 8'h84;
    localparam logic [7:0] ADDR_PART_HIGH      = 8'h86;
    localparam logic [7:0] ADDR_PART_LOW_REV   = 8'h87;
    localparam logic [7:0] ADDR_RESET_CAL      = 8'h88;
    localparam logic [7:0] ADDR_QUICK_LOCK     = 8'h89;
    localparam logic [7:0] ADDR_LOSS_EN_HIGH   = 8'h8A;
    localparam logic [7:0] ADDR_LOSS_OFS_EN    = 8'h8B;
    localparam logic [7:0] ADDR_OUT1_SKEW      = 8'h8E;
    localparam logic [7:0] ADDR_OUT2_SKEW      = 8'h8F;

    // reset values and writable masks of the two control registers
    localparam logic [7:0] CONTROL_MODE_RESET   = 8'h14;
    localparam logic [7:0] CONTROL_MODE_WMASK   = 8'h62;
    localparam logic [7:0] INPUT_PRIORITY_RESET = 8'hE4;
    localparam logic [7:0] INPUT_PRIORITY_WMASK = 8'h0F;
    localparam logic [7:0] BYTE_RESET           = 8'h00;

    // field positions
    localparam int FREE_RUN_BIT       = 6;
    localparam int UNSQUELCH_BIT      = 5;
    localparam int BYPASS_BIT         = 1;
    localparam int PRIO1_LSB          = 0;
    localparam int PRIO2_LSB          = 2;
    localparam int FB_HS_LSB          = 5;
    localparam int SOFT_RESET_BIT     = 7;
    localparam int CAL_START_BIT      = 6;
    localparam int HOLD_VALID_BIT     = 6;
    localparam int OFFSET_FLAG_LSB    = 1;

    // input and method codes
    localparam logic [1:0] INPUT_CODE_ONE    = 2'h0;
    localparam logic [1:0] INPUT_CODE_TWO    = 2'h1;
    localparam logic [1:0] METHOD_MANUAL     = 2'h0;
    localparam logic [1:0] METHOD_NONREVERT  = 2'h1;
    localparam logic [1:0] METHOD_REVERT     = 2'h2;

    typedef enum logic [1:0] {SEL_ONE, SEL_TWO, SEL_HOLD} sel_t;

    typedef struct packed {
        logic       wr;     // write strobe, one cycle
        logic       rd;     // read strobe, one cycle
        logic [7:0] addr;   // register number
        logic [7:0] wdata;  // write byte
    } reg_req_t;

    typedef struct packed {
        logic        ref_to_input_two;  // reference oscillator routed to input path two
        logic        bypass;            // selected input drives outputs directly
        logic        outputs_on;        // output clocks unsquelched
        logic        holdover;          // loop in holdover
        logic        input_two_active;  // 1: input two in use, 0: input one or holdover
        logic [15:0] out2_div_low;      // output-2 low-speed divider bits 15:0
        logic [2:0]  fb_div_high;       // feedback high-speed divider
        logic [19:0] fb_div_low;        // feedback low-speed divider
        logic [18:0] in1_div;           // input-one divider
        logic [18:0] in2_div;           // input-two divider
        logic [7:0]  rate_ranges;       // input rate range codes
        logic        quick_lock;        // fast lock enable
        logic [3:0]  loss_enables;      // {in2 hi, in1 hi, in2 lo, in1 lo}
        logic [1:0]  offset_enables;    // {in2, in1}
        logic [7:0]  out1_skew;         // output-1 skew
        logic [7:0]  out2_skew;         // output-2 skew
        logic        soft_reset;        // one-cycle pulse
        logic        cal_start;         // one-cycle pulse
    } cfg_t;

    typedef struct packed {
        logic [7:0] control_mode;
        logic [7:0] input_priority;
        logic [7:0] out2_mid, out2_low, fb_high, fb_mid, fb_low;
        logic [7:0] in1_high, in1_mid, in1_low, in2_high, in2_mid, in2_low;
        logic [7:0] rate_ranges, quick_lock, loss_en_high, loss_ofs_en;
        logic [7:0] out1_skew, out2_skew;
        logic [2:0] loss_flags;
        logic [2:0] offset_flags;
        logic       soft_reset;
        logic       cal_start;
        logic       cal_seen;
        logic       cal_good;
        sel_t       sel;
        logic [7:0] rdata;
    } bank_state_t;

endpackage : clkmul_regs_pkg

// file: sim/tb_top.sv
// self-checking bench for the clock multiplier configuration bank
// assumes the bank's own assertions sit in the design file; bench drives on falling edges
`timescale 1ns/1ps

module tb_top;
    import clkmul_regs_pkg::*;

    logic       sys_clk, nrst, forced_holdover, squelch_during_calibration, cal_done, loss_of_lock;
    logic [1:0] input_ok, input_select_method, manual_select;
    logic [2:0] loss_status;
    logic [7:0] rdata;
    reg_req_t   req;
    cfg_t       cfg;
    int         num_errors, tests_run;

    clock_multiplier_config_regs i_dut (.sys_clk(sys_clk), .nrst(nrst), .req(req), .rdata(rdata),
        .input_ok(input_ok), .loss_status(loss_status), .offset_status(2'h0),
        .loss_of_lock(loss_of_lock), .hold_valid(1'b0), .input_select_method(input_select_method),
        .manual_select(manual_select), .forced_holdover(forced_holdover),
        .squelch_during_calibration(squelch_during_calibration), .cal_done(cal_done), .cfg(cfg));

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic print_verdict();
        if (num_errors == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] seen);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // one-cycle strobes; the extra edge lets cfg and rdata settle before anyone looks
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge sys_clk);
        req.wr = 1'b0;
        @(negedge sys_clk);
    endtask : wr

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge sys_clk);
        req.rd = 1'b0;
        @(negedge sys_clk);
        chk(what, exp, rdata);
    endtask : rd_chk

    task automatic settle(input logic [1:0] ok);
        input_ok = ok;
        repeat (2) @(negedge sys_clk);
    endtask : settle

    task automatic test_reset();
        rd_chk("reg0 reset", ADDR_CONTROL_MODE, 8'h14);
        rd_chk("reg1 reset", ADDR_INPUT_PRIORITY, 8'hE4);
        rd_chk("unmapped read", 8'h40, 8'h00);
        chk("outputs_on", 1'b0, cfg.outputs_on);
    endtask : test_reset

    task automatic test_control();
        // reserved bits at reset; bypass before any calibration, no CMOS format
        wr(ADDR_CONTROL_MODE, 8'h76);
        rd_chk("reg0 masked", ADDR_CONTROL_MODE, 8'h76);
        chk("free run", 1'b1, cfg.ref_to_input_two);
        chk("bypass", 1'b1, cfg.bypass);
        chk("outputs_on", 1'b1, cfg.outputs_on);
        wr(ADDR_CONTROL_MODE, 8'h14);
        rd_chk("reg0 cleared", ADDR_CONTROL_MODE, 8'h14);
        chk("free run", 1'b0, cfg.ref_to_input_two);
        chk("bypass", 1'b0, cfg.bypass);
    endtask : test_control

    task automatic test_priority();
        wr(ADDR_INPUT_PRIORITY, 8'hEF);
        rd_chk("reg1 masked", ADDR_INPUT_PRIORITY, 8'hEF);
        // first choice input two, second input one
        wr(ADDR_INPUT_PRIORITY, 8'hE1);
        input_select_method = METHOD_REVERT;
        settle(2'b11);
        chk("first priority", 1'b1, cfg.input_two_active);
        settle(2'b01);
        chk("second priority", 1'b0, cfg.input_two_active);
        settle(2'b00);
        chk("no input holdover", 1'b1, cfg.holdover);
        settle(2'b11);
        chk("revert", 1'b1, cfg.input_two_active);
        input_select_method = METHOD_NONREVERT;
        settle(2'b01);
        settle(2'b11);
        chk("no revert", 1'b0, cfg.input_two_active);
        forced_holdover = 1'b1;
        settle(2'b11);
        chk("forced hold", 1'b1, cfg.holdover);
        forced_holdover = 1'b0;
        input_select_method = METHOD_MANUAL;
        manual_select = INPUT_CODE_TWO;
        settle(2'b11);
        chk("manual two", 1'b1, cfg.input_two_active);
    endtask : test_priority

    task automatic test_divider();
        wr(ADDR_IN1_DIV_HIGH, 8'h05);
        wr(ADDR_IN1_DIV_MID, 8'h12);
        wr(ADDR_IN1_DIV_LOW, 8'h34);
        chk("in1 divider", 19'h51234, cfg.in1_div);
        rd_chk("in1 mid", ADDR_IN1_DIV_MID, 8'h12);
        wr(ADDR_FB_DIV_HIGH, 8'hAF);
        chk("fb high", 3'h5, cfg.fb_div_high);
        chk("fb low top", 4'hF, cfg.fb_div_low[19:16]);
    endtask : test_divider

    task automatic test_back_to_back();
        req = '{wr: 1'b1, rd: 1'b0, addr: ADDR_INPUT_PRIORITY, wdata: 8'hE5};
        @(negedge sys_clk);
        req = '{wr: 1'b0, rd: 1'b1, addr: ADDR_INPUT_PRIORITY, wdata: 8'h00};
        @(negedge sys_clk);
        req.rd = 1'b0;
        @(negedge sys_clk);
        chk("reg1 back to back", 8'hE5, rdata);
    endtask : test_back_to_back

    task automatic test_flags();
        loss_status = 3'h3;
        rd_chk("loss live", ADDR_LOSS_STATUS, 8'h03);
        wr(ADDR_LOSS_FLAGS, 8'h00);
        rd_chk("flag kept", ADDR_LOSS_FLAGS, 8'h03);
        loss_status = 3'h0;
        wr(ADDR_LOSS_FLAGS, 8'h00);
        rd_chk("flag cleared", ADDR_LOSS_FLAGS, 8'h00);
    endtask : test_flags

    task automatic test_calibration();
        squelch_during_calibration = 1'b1;
        loss_of_lock = 1'b1;
        cal_done = 1'b1;
        @(negedge sys_clk);
        cal_done = 1'b0;
        repeat (3) @(negedge sys_clk);
        chk("squelched unlocked", 1'b0, cfg.outputs_on);
        loss_of_lock = 1'b0;
        for (int i = 0; i < 8 && cfg.outputs_on !== 1'b1; i++) @(negedge sys_clk);
        chk("unsquelched locked", 1'b1, cfg.outputs_on);
        if (cfg.outputs_on !== 1'b1) print_verdict();
    endtask : test_calibration

    initial begin
        nrst = 1'b0;
        req = '0;
        input_ok = 2'b11;
        input_select_method = METHOD_MANUAL;
        {forced_holdover, squelch_during_calibration, cal_done, loss_of_lock} = 4'h0;
        {loss_status, manual_select} = 5'h00;
        num_errors = 0;
        tests_run = 0;
        repeat (6) @(negedge sys_clk);
        nrst = 1'b1;
        @(negedge sys_clk);
        test_reset();
        test_control();
        test_back_to_back();
        test_priority();
        test_divider();
        test_flags();
        test_calibration();
        print_verdict();
    end
endmodule : tb_top
